// *** design/uwrl_pkg.sv ***
// package of constants and types for the unaligned word right-load datapath
package uwrl_pkg;
  localparam int          UWRL_XLEN          = 64;
  localparam int          UWRL_WORD          = 32;
  localparam int          UWRL_PADDR_W       = 36;
  localparam logic [5:0]  UWRL_OP_RIGHT      = 6'h26;  // load_word_right_op major opcode
  localparam logic [5:0]  UWRL_OP_GROUP3     = 6'h1f;  // major_opcode_group_three
  localparam logic [5:0]  UWRL_FN_USER_RIGHT = 6'h1a;  // user_space_right_load_op function
  localparam int          UWRL_OFF9_W        = 9;
  localparam int          UWRL_OFF9_LSB      = 7;
  localparam int          UWRL_ZERO_BIT      = 6;
  localparam logic [1:0]  UWRL_FULL_BE       = 2'h3;   // big-endian offset loading all 4 bytes
  localparam logic [2:0]  UWRL_ALIGN_MASK    = 3'h0;
  // segment access modes seen by the user-space variant
  typedef enum logic [2:0] {
    UWRL_SEG_KERNEL  = 3'b000,
    UWRL_SEG_DUAL    = 3'b001,  // dual_mapped_segment_mode
    UWRL_SEG_UNMAP_U = 3'b010,  // unmapped_user_segment_mode
    UWRL_SEG_MAP_SUP = 3'b011,  // mapped_supervisor_segment_mode
    UWRL_SEG_OTHER   = 3'b100
  } uwrl_seg_t;
  typedef enum logic [1:0] {
    UWRL_IDLE = 2'b00,
    UWRL_XLAT = 2'b01,
    UWRL_MEM  = 2'b10
  } uwrl_state_t;
endpackage

// *** design/uwrl_merge.sv ***
// byte merge of a right-load into the low destination word
`timescale 1ns/1ps
`default_nettype none
module uwrl_merge
  import uwrl_pkg::*;
#(
  parameter bit KEEP_UPPER = 1'b1
) (
  // operands
  input  wire logic [1:0]  offset_i,
  input  wire logic        big_endian_i,
  input  wire logic [31:0] mem_word_i,
  input  wire logic [63:0] old_i,
  // result
  output logic [63:0]      result_o
);
  logic [1:0]  nbytes_m1;
  logic [1:0]  shift;
  logic [31:0] shifted;
  logic [31:0] keep_mask;
  logic [31:0] low;
  logic        full;
  // big-endian n loads the n+1 low bytes; little-endian loads from offset n up
  assign nbytes_m1 = big_endian_i ? offset_i : (UWRL_FULL_BE - offset_i);
  assign shift     = big_endian_i ? (UWRL_FULL_BE - offset_i) : offset_i;
  assign shifted   = mem_word_i >> {shift, 3'h0};
  assign keep_mask = ~(32'hffffffff >> {(UWRL_FULL_BE - nbytes_m1), 3'h0});
  assign low       = (old_i[31:0] & keep_mask) | (shifted & ~keep_mask);
  assign full      = (nbytes_m1 == UWRL_FULL_BE);
  // sign extension when bit 31 loaded, otherwise fixed choice
  assign result_o  = full ? {{32{low[31]}}, low}
                   : (KEEP_UPPER ? {old_i[63:32], low} : {{32{old_i[31]}}, low});
endmodule
`default_nettype wire

// *** design/uwrl_core.sv ***
// right-load datapath: decode, address, translation request, merge and write-back
`timescale 1ns/1ps
`default_nettype none
module uwrl_core
  import uwrl_pkg::*;
#(
  parameter bit KEEP_UPPER = 1'b1
) (
  // clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    sys_rst_i,
  // issue from pipeline
  input  wire logic                    issue_valid_i,
  input  wire logic [31:0]             instr_i,
  input  wire logic [63:0]             base_val_i,
  input  wire logic [63:0]             target_val_i,
  // configuration
  input  wire logic                    extended_va_enable_field_i,
  input  wire logic                    cpu_byte_order_flag_i,
  input  wire logic                    swapped_byte_order_flag_i,
  input  wire logic                    memory_byte_order_flag_i,
  input  wire logic [2:0]              seg_mode_i,
  // translation answer
  input  wire logic                    xlat_done_i,
  input  wire logic [UWRL_PADDR_W-1:0] xlat_paddr_i,
  input  wire logic                    xlat_refill_i,
  input  wire logic                    xlat_invalid_i,
  input  wire logic                    xlat_addr_err_i,
  input  wire logic                    xlat_watch_i,
  // memory answer
  input  wire logic                    mem_done_i,
  input  wire logic [63:0]             mem_dword_i,
  input  wire logic                    mem_bus_err_i,
  // translation request
  output logic                         xlat_req_o,
  output logic [63:0]                  xlat_vaddr_o,
  output logic                         xlat_user_map_o,
  // memory request
  output logic                         mem_req_o,
  output logic [UWRL_PADDR_W-1:0]      mem_paddr_o,
  // write-back and status
  output logic                         busy_o,
  output logic                         wb_valid_o,
  output logic [4:0]                   wb_reg_o,
  output logic [63:0]                  wb_data_o,
  output logic                         reserved_instr_o,
  output logic                         exc_valid_o,
  output logic [2:0]                   exc_code_o
);
  // exception codes driven on exc_code_o
  localparam logic [2:0] EXC_REFILL  = 3'h1;
  localparam logic [2:0] EXC_INVALID = 3'h2;
  localparam logic [2:0] EXC_BUS     = 3'h3;
  localparam logic [2:0] EXC_ADDR    = 3'h4;
  localparam logic [2:0] EXC_WATCH   = 3'h5;

  uwrl_state_t state_q, state_d;
  logic [63:0]             vaddr_q;
  logic [4:0]              rt_q;
  logic [63:0]             old_q;
  logic                    user_q;
  logic [UWRL_PADDR_W-1:0] paddr_q;
  logic                    xlat_req_q, mem_req_q;
  logic                    busy_q;
  logic                    wb_valid_q;
  logic [4:0]              wb_reg_q;
  logic [63:0]             wb_data_q;
  logic                    ri_q, exc_q;
  logic [2:0]              exc_code_q;

  // sign extension, one function per offset width
  function automatic logic [63:0] sext16(input logic [15:0] v);
    sext16 = {{48{v[15]}}, v};
  endfunction
  function automatic logic [63:0] sext9(input logic [8:0] v);
    sext9 = {{55{v[8]}}, v};
  endfunction

  // instruction decode
  wire [5:0] opc       = instr_i[31:26];
  wire [5:0] fnc       = instr_i[5:0];
  wire [4:0] rt_fld    = instr_i[20:16];
  wire       is_plain  = (opc == UWRL_OP_RIGHT);
  wire       is_user_e = (opc == UWRL_OP_GROUP3) && (fnc == UWRL_FN_USER_RIGHT)
                         && !instr_i[UWRL_ZERO_BIT];
  wire       is_user   = is_user_e && extended_va_enable_field_i;
  wire       user_ri   = is_user_e && !extended_va_enable_field_i;
  wire       start     = issue_valid_i && (state_q == UWRL_IDLE) && (is_plain || is_user);

  // effective address, no alignment check
  wire [63:0] off_ext  = is_user ? sext9(instr_i[UWRL_OFF9_LSB +: UWRL_OFF9_W])
                                 : sext16(instr_i[15:0]);
  wire [63:0] eff_addr = base_val_i + off_ext;

  // back-to-back to same destination uses prior result
  wire        fwd      = wb_valid_q && (wb_reg_q == rt_fld);
  wire [63:0] old_val  = fwd ? wb_data_q : target_val_i;

  // segment mode check for user variant
  wire seg_ok = (seg_mode_i == UWRL_SEG_DUAL) || (seg_mode_i == UWRL_SEG_UNMAP_U)
                || (seg_mode_i == UWRL_SEG_MAP_SUP);
  wire xlat_fault = xlat_refill_i || xlat_invalid_i || xlat_addr_err_i || xlat_watch_i
                    || (user_q && !seg_ok);
  wire [2:0] xlat_code = xlat_refill_i  ? EXC_REFILL
                       : xlat_invalid_i ? EXC_INVALID
                       : xlat_watch_i   ? EXC_WATCH
                       : EXC_ADDR;

  // physical address adjustment
  wire [2:0] low_x = xlat_paddr_i[2:0] ^ {3{swapped_byte_order_flag_i}};
  wire [2:0] low_p = memory_byte_order_flag_i ? low_x : UWRL_ALIGN_MASK;
  wire [UWRL_PADDR_W-1:0] paddr_adj = {xlat_paddr_i[UWRL_PADDR_W-1:3], low_p};

  // word half of the doubleword
  wire        word_sel = vaddr_q[2] ^ cpu_byte_order_flag_i;
  wire [31:0] mem_word = word_sel ? mem_dword_i[63:32] : mem_dword_i[31:0];
  wire [63:0] merged;

  uwrl_merge #(
    .KEEP_UPPER (KEEP_UPPER)
  ) u_merge (
    .offset_i     (vaddr_q[1:0]),
    .big_endian_i (cpu_byte_order_flag_i),
    .mem_word_i   (mem_word),
    .old_i        (old_q),
    .result_o     (merged)
  );

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      UWRL_IDLE: if (start) state_d = UWRL_XLAT;
      UWRL_XLAT: if (xlat_done_i) state_d = xlat_fault ? UWRL_IDLE : UWRL_MEM;
      UWRL_MEM:  if (mem_done_i) state_d = UWRL_IDLE;
      default:   state_d = UWRL_IDLE;
    endcase
  end

  // state and captured operands
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_q <= UWRL_IDLE;
      vaddr_q <= 64'h0;
      rt_q    <= 5'h0;
      old_q   <= 64'h0;
      user_q  <= 1'b0;
      paddr_q <= '0;
    end else begin
      state_q <= state_d;
      if (start) begin
        vaddr_q <= eff_addr;
        rt_q    <= rt_fld;
        old_q   <= old_val;
        user_q  <= is_user;
      end
      if (state_q == UWRL_XLAT && xlat_done_i) paddr_q <= paddr_adj;
    end
  end

  // request strobes held until answered
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      xlat_req_q <= 1'b0;
      mem_req_q  <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      xlat_req_q <= (state_d == UWRL_XLAT);
      mem_req_q  <= (state_d == UWRL_MEM);
      busy_q     <= (state_d == UWRL_XLAT) || (state_d == UWRL_MEM); // same edge as the strobes
    end
  end

  // write-back or exception, never both
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wb_valid_q <= 1'b0;
      wb_reg_q   <= 5'h0;
      wb_data_q  <= 64'h0;
      ri_q       <= 1'b0;
      exc_q      <= 1'b0;
      exc_code_q <= 3'h0;
    end else begin
      wb_valid_q <= (state_q == UWRL_MEM) && mem_done_i && !mem_bus_err_i;
      if ((state_q == UWRL_MEM) && mem_done_i && !mem_bus_err_i) begin
        wb_reg_q  <= rt_q;
        wb_data_q <= merged;
      end
      ri_q       <= issue_valid_i && (state_q == UWRL_IDLE) && user_ri;
      exc_q      <= ((state_q == UWRL_XLAT) && xlat_done_i && xlat_fault)
                    || ((state_q == UWRL_MEM) && mem_done_i && mem_bus_err_i);
      exc_code_q <= (state_q == UWRL_MEM) ? EXC_BUS : xlat_code;
    end
  end

  // outputs straight from flops
  assign xlat_req_o       = xlat_req_q;
  assign xlat_vaddr_o     = vaddr_q;
  assign xlat_user_map_o  = user_q;
  assign mem_req_o        = mem_req_q;
  assign mem_paddr_o      = paddr_q;
  assign busy_o           = busy_q;
  assign wb_valid_o       = wb_valid_q;
  assign wb_reg_o         = wb_reg_q;
  assign wb_data_o        = wb_data_q;
  assign reserved_instr_o = ri_q;
  assign exc_valid_o      = exc_q;
  assign exc_code_o       = exc_code_q;
endmodule
`default_nettype wire

// *** verif/uwrl_core_sva.sv ***
// assertion checker on the right-load datapath ports
`timescale 1ns/1ps
`default_nettype none
module uwrl_core_sva
  import uwrl_pkg::*;
(
  // watched ports
  input wire logic                    core_clk_i, sys_rst_i, issue_valid_i, extended_va_enable_field_i, busy_o,
  input wire logic                    swapped_byte_order_flag_i, memory_byte_order_flag_i, xlat_done_i,
  input wire logic                    xlat_refill_i, mem_done_i, mem_bus_err_i, xlat_req_o, xlat_user_map_o,
  input wire logic                    mem_req_o, wb_valid_o, exc_valid_o, reserved_instr_o,
  input wire logic [31:0]             instr_i,
  input wire logic [63:0]             base_val_i, xlat_vaddr_o,
  input wire logic [2:0]              seg_mode_i, exc_code_o,
  input wire logic [UWRL_PADDR_W-1:0] xlat_paddr_i, mem_paddr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // expected addresses from the current inputs
  wire logic take_w = issue_valid_i && !busy_o;
  wire logic [63:0] ea16_w = base_val_i + {{48{instr_i[15]}}, instr_i[15:0]};
  wire logic [63:0] ea9_w = base_val_i + {{55{instr_i[15]}}, instr_i[15:7]};
  wire logic [UWRL_PADDR_W-1:0] pfix_w = {xlat_paddr_i[UWRL_PADDR_W-1:3],
    memory_byte_order_flag_i ? xlat_paddr_i[2:0] ^ {3{swapped_byte_order_flag_i}} : UWRL_ALIGN_MASK};
  sequence s_user;
    take_w && instr_i[31:26] == UWRL_OP_GROUP3 && instr_i[5:0] == UWRL_FN_USER_RIGHT && !instr_i[UWRL_ZERO_BIT];
  endsequence
  sequence s_xlat_clean;
    xlat_req_o && xlat_done_i ##1 !exc_valid_o;
  endsequence
  // request order and values
  chk_plain_addr: assert property (take_w && instr_i[31:26] == UWRL_OP_RIGHT |=>
    xlat_req_o && !exc_valid_o && xlat_vaddr_o == $past(ea16_w)) else $error("plain address wrong");
  chk_user_addr: assert property (s_user ##0 extended_va_enable_field_i && seg_mode_i == UWRL_SEG_DUAL |=>
    xlat_req_o && xlat_user_map_o && xlat_vaddr_o == $past(ea9_w)) else $error("user address wrong");
  chk_no_eva: assert property (s_user ##0 !extended_va_enable_field_i |=>
    reserved_instr_o && !xlat_req_o) else $error("reserved instruction missing");
  chk_paddr_fix: assert property (s_xlat_clean |->
    mem_req_o && mem_paddr_o == $past(pfix_w)) else $error("physical address wrong");
  chk_refill_exc: assert property (xlat_req_o && xlat_done_i && xlat_refill_i |=>
    exc_valid_o && exc_code_o == 3'h1 && !mem_req_o) else $error("refill not reported");
  chk_bus_exc: assert property (mem_req_o && mem_done_i && mem_bus_err_i |=>
    exc_valid_o && exc_code_o == 3'h3 && !wb_valid_o) else $error("bus error not reported");
  chk_wb_pulse: assert property (mem_req_o && mem_done_i && !mem_bus_err_i |=>
    wb_valid_o && !exc_valid_o ##1 !wb_valid_o) else $error("write-back pulse wrong");
  chk_req_stands: assert property (xlat_req_o && !xlat_done_i |=>
    xlat_req_o && $stable(xlat_vaddr_o)) else $error("translation request dropped");
endmodule
bind uwrl_core uwrl_core_sva uwrl_core_sva_inst (.core_clk_i, .sys_rst_i, .issue_valid_i, .extended_va_enable_field_i,
  .busy_o, .swapped_byte_order_flag_i, .memory_byte_order_flag_i, .xlat_done_i, .xlat_refill_i, .mem_done_i,
  .mem_bus_err_i, .xlat_req_o, .xlat_user_map_o, .mem_req_o, .wb_valid_o, .exc_valid_o, .reserved_instr_o,
  .instr_i, .base_val_i, .xlat_vaddr_o, .seg_mode_i, .exc_code_o, .xlat_paddr_i, .mem_paddr_o);
`default_nettype wire

// *** verif/uwrl_far_end.sv ***
// far-side model: translation and data memory with adjustable answer delay
`timescale 1ns/1ps
`default_nettype none
module uwrl_far_end
  import uwrl_pkg::*;
(
  // clock, reset, requests and scenario controls
  input  wire logic                    clk_i, rst_i, xreq_i, mreq_i,
  input  wire logic [1:0]              wait_i,
  input  wire logic [2:0]              fault_i,
  input  wire logic [63:0]             va_i, dw_i,
  // answers
  output logic                         xdone_o, mdone_o,
  output logic [4:0]                   flt_o,
  output logic [UWRL_PADDR_W-1:0]      pa_o,
  output logic [63:0]                  dw_o
);
  logic [1:0] cnt_q;
  // wait out the delay, then one done pulse per request
  always_ff @(posedge clk_i) begin
    cnt_q <= (rst_i || xdone_o || mdone_o || !(xreq_i || mreq_i)) ? 2'h0 : cnt_q + 2'h1;
    xdone_o <= !rst_i && !xdone_o && !mdone_o && xreq_i && cnt_q == wait_i;
    mdone_o <= !rst_i && !xdone_o && !mdone_o && mreq_i && cnt_q == wait_i;
  end
  // faults ride with done only; idle data lines show the inverse
  assign flt_o = {5{xdone_o | mdone_o}} & (5'h1 << (fault_i - 3'h1)) & (mdone_o ? 5'h4 : 5'h1b);
  assign pa_o = xdone_o ? va_i[UWRL_PADDR_W-1:0] : ~va_i[UWRL_PADDR_W-1:0];
  assign dw_o = mdone_o ? dw_i : ~dw_i;
endmodule
`default_nettype wire

// *** verif/uwrl_core_test.sv ***
// self-checking bench for the right-load datapath
`timescale 1ns/1ps
`default_nettype none
module uwrl_core_test;
  import uwrl_pkg::*;
  logic clk, rst, iv, eva, be, sw, mb, xd, md, xr, um, mr, bz, wv, ri, ev;
  logic [1:0] wt;
  logic [2:0] seg, flt, ec;
  logic [4:0] fl, wr;
  logic [31:0] ins;
  logic [35:0] pa, mpa;
  logic [63:0] base, tgt, dw, mw, va, wd, last;
  int n_errors = 0;
  int compares = 0;
  uwrl_core uwrl_core_inst (.core_clk_i(clk), .sys_rst_i(rst), .issue_valid_i(iv), .instr_i(ins), .base_val_i(base),
    .target_val_i(tgt), .extended_va_enable_field_i(eva), .cpu_byte_order_flag_i(be), .swapped_byte_order_flag_i(sw),
    .memory_byte_order_flag_i(mb), .seg_mode_i(seg), .xlat_done_i(xd), .xlat_paddr_i(pa), .xlat_refill_i(fl[0]),
    .xlat_invalid_i(fl[1]), .mem_bus_err_i(fl[2]), .xlat_addr_err_i(fl[3]), .xlat_watch_i(fl[4]), .mem_done_i(md),
    .mem_dword_i(mw), .xlat_req_o(xr), .xlat_vaddr_o(va), .xlat_user_map_o(um), .mem_req_o(mr), .mem_paddr_o(mpa),
    .busy_o(bz), .wb_valid_o(wv), .wb_reg_o(wr), .wb_data_o(wd), .reserved_instr_o(ri), .exc_valid_o(ev),
    .exc_code_o(ec));
  uwrl_far_end uwrl_far_end_inst (.clk_i(clk), .rst_i(rst), .xreq_i(xr), .mreq_i(mr), .wait_i(wt), .fault_i(flt),
    .va_i(va), .dw_i(dw), .xdone_o(xd), .mdone_o(md), .flt_o(fl), .pa_o(pa), .dw_o(mw));
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare and count
  task automatic check(input string n, input logic [71:0] s, e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one load: x is the expected exception code, 0 for write-back, 7 for reserved
  task automatic run(input logic [31:0] i, input logic [63:0] b, d, input logic [2:0] f, x, input bit b2b);
    logic [63:0] v, o, r;
    logic [35:0] p;
    logic [1:0] k;
    int c;
    if (!b2b) @(posedge clk) #1;
    v = b + (i[31:26] == UWRL_OP_RIGHT ? {{48{i[15]}}, i[15:0]} : {{55{i[15]}}, i[15:7]});
    o = b2b ? last : b ^ 64'hc3c3_5a5a_0ff0_8118;
    k = v[1:0] ^ {2{be}};
    r = {o[63:32], (o[31:0] & ~(32'hffffffff >> {k, 3'h0})) | (d[{v[2] ^ be, 5'h0} +: 32] >> {k, 3'h0})};
    if (k == 2'h0) r[63:32] = {32{r[31]}};
    if (x != 3'h0) r = last;
    {ins, base, dw, flt, tgt, iv, p} = {i, b, d, f, b2b ? ~last : o, 1'b1, 36'h0};
    @(posedge clk) #1 iv = 1'b0;
    check("busy", 72'(bz), 72'(x != 3'h7));
    for (c = 0; c < 20 && !(wv === 1'b1 || ev === 1'b1 || ri === 1'b1); c++) begin
      if (mr === 1'b1) p = mpa;
      @(posedge clk) #1;
    end
    if (c == 20) begin
      n_errors++;
      finish_test();
    end
    check("result", {wv, ev, ri, ev ? ec : 3'h0, wd}, {x == 3'h0, x != 3'h0 && x != 3'h7, x == 3'h7,
      x == 3'h7 ? 3'h0 : x, r});
    if (x == 3'h0) check("paddr", 72'(p), 72'({v[35:3], mb ? v[2:0] ^ {3{sw}} : 3'h0}));
    if (x == 3'h0) check("reg", 72'(wr), 72'h3);
    last = r;
  endtask
  // every offset in both byte orders, both word halves
  task automatic t_bytes;
    for (int n = 0; n < 16; n++) begin
      be = n[3];
      run({UWRL_OP_RIGHT, 10'h23, 16'hfff8}, 64'h1008 + 64'(n[2:0]), 64'h7899aabb_91223344, 3'h0, 3'h0, 1'b0);
    end
    $display("bytes test done");
  endtask
  // user variant in segment modes 0 to 3 (not UWRL_SEG_OTHER), then with the extension off
  task automatic t_user;
    for (int s = 0; s < 5; s++) begin
      eva = s < 4;
      seg = s < 4 ? 3'(s) : 3'h1;
      run({UWRL_OP_GROUP3, 10'h23, 9'h1fd, 1'b0, UWRL_FN_USER_RIGHT}, 64'h2006, 64'h0e0d0c0b_8a090807, 3'h0,
        s == 4 ? 3'h7 : s == 0 ? 3'h4 : 3'h0, 1'b0);
    end
    eva = 1'b1;
    $display("user test done");
  endtask
  // every fault with answer waits from 0 to 3, then address swizzle and alignment
  task automatic t_faults;
    for (int f = 1; f < 8; f++) begin
      wt = 2'(f);
      sw = f > 5;
      mb = f != 7;
      run({UWRL_OP_RIGHT, 10'h23, 16'h0005}, 64'h3000, 64'h11112222_83334444, f > 5 ? 3'h0 : 3'(f), f > 5 ? 3'h0 : 3'(f),
        1'b0);
    end
    {wt, sw, mb} = 4'h1;
    $display("faults test done");
  endtask
  // back-to-back loads to one destination merge through forwarding
  task automatic t_fwd;
    be = 1'b0;
    run({UWRL_OP_RIGHT, 10'h23, 16'h0000}, 64'h4002, 64'h01234567_89abcdef, 3'h0, 3'h0, 1'b0);
    run({UWRL_OP_RIGHT, 10'h23, 16'h0000}, 64'h4005, 64'h01234567_89abcdef, 3'h0, 3'h0, 1'b1);
    $display("forward test done");
  endtask
  // reset, then the scenarios
  initial begin
    {rst, iv, eva, be, sw, mb, seg, flt, wt, ins, base, tgt, dw, last} = {6'h29, 3'h1, 5'h0, 288'h0};
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    t_bytes();
    t_user();
    t_faults();
    t_fwd();
    finish_test();
  end
endmodule
`default_nettype wire
